// ---- rtl/fppg_defs.vh ----
`ifndef FPPG_DEFS_VH
`define FPPG_DEFS_VH

// Register byte offsets.
`define FPPG_OFF_LOCK 8'h00
`define FPPG_OFF_PW_STORE 8'h04
`define FPPG_OFF_PW_INPUT 8'h08
`define FPPG_OFF_HOLD 8'h0C
`define FPPG_OFF_WORKBIT 8'h10
`define FPPG_OFF_ROUTE 8'h14
`define FPPG_OFF_STATUS 8'h18
`define FPPG_OFF_COND 8'h1C

// Lock register field positions.
`define FPPG_LOCK_OPADJ_LSB 0
`define FPPG_LOCK_INIT_LSB 2
`define FPPG_LOCK_CHANGE_BIT 4
`define FPPG_LOCK_FKEY_BIT 5

// Reset values.
`define FPPG_RST_LOCK 32'h00000000
`define FPPG_RST_PW 16'h0000
`define FPPG_RST_WORKBIT 32'h00001307
`define FPPG_RST_ROUTE 32'h00000000
`define FPPG_RST_COND 8'hFF

// Key-hold timing: hold time in milliseconds, counted in 1 ms ticks.
`define FPPG_HOLD_MS 16'h0BB8
`define FPPG_CLOCK_HZ 10000000
`define FPPG_TICK_MS 1
`define FPPG_TICK_CYCLES ((`FPPG_CLOCK_HZ / 1000) * `FPPG_TICK_MS)

// Work-bit input selection codes.
`define FPPG_SEL_OFF 5'h00
`define FPPG_SEL_ALARM1 5'h07
`define FPPG_SEL_RUN_INV 5'h13

// Output route codes.
`define FPPG_ROUTE_NONE 2'h0
`define FPPG_ROUTE_ALARM1 2'h1
`define FPPG_ROUTE_WORKBIT 2'h2
`define FPPG_ROUTE_CONTROL 2'h3

// AXI responses.
`define FPPG_RESP_OKAY 2'h0
`define FPPG_RESP_SLVERR 2'h2

`endif

// ---- rtl/fppg_hold_timer.v ----
`timescale 1ns/1ps
`include "fppg_defs.vh"

// Measures how long both entry keys stay pressed together.
module fppg_hold_timer #(
  parameter TICK_CYCLES = `FPPG_TICK_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire keys_held,
  input wire [15:0] hold_ms,
  output reg reached
);
  reg [23:0] prescale;
  reg [15:0] elapsed;
  reg armed;

  // A release restarts the count; one pulse per continuous hold.
  always @(posedge clk)
  begin
    if (rst || !keys_held)
    begin
      prescale <= 24'h000000;
      elapsed <= 16'h0000;
      armed <= 1'b1;
      reached <= 1'b0;
    end
    else
    begin
      reached <= 1'b0;
      if (armed && elapsed >= hold_ms)
      begin
        reached <= 1'b1;
        armed <= 1'b0;
      end
      else if (prescale == TICK_CYCLES - 1)
      begin
        prescale <= 24'h000000;
        if (elapsed != 16'hFFFF)
          elapsed <= elapsed + 16'h0001;
      end
      else
        prescale <= prescale + 24'h000001;
    end
  end
endmodule

// ---- rtl/fppg_top.v ----
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "fppg_defs.vh"

module fppg_top #(
  parameter TICK_CYCLES = `FPPG_TICK_CYCLES,
  parameter HAS_FKEY = 1,
  parameter NCOND = 8
) (
  input wire CLOCK,
  input wire RST,
  input wire KEY_LEVEL,
  input wire KEY_MODE,
  input wire ALARM1,
  input wire RUN,
  input wire CONTROL_OUT,
  input wire [NCOND-1:0] COND_MET,
  output reg IN_PROTECT,
  output reg SHOW_PW_PROMPT,
  output reg SHOW_LOCK_SETTINGS,
  output reg SHOW_PV,
  output reg SHOW_SP,
  output reg SP_EDITABLE,
  output reg [NCOND-1:0] SHOW_OTHER,
  output reg ADJ_ALLOWED,
  output reg INIT_ALLOWED,
  output reg COMM_ALLOWED,
  output reg ADV_ALLOWED,
  output reg KEY_CHANGE_ALLOWED,
  output reg FKEY_ALLOWED,
  output reg ALARM_PARAMS_ON,
  output reg OUT_CTRL1,
  output reg OUT_CTRL2,
  output reg OUT_AUX1,
  output reg OUT_AUX2,
  output reg OUT_AUX3,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  localparam ST_OPER = 2'h0;
  localparam ST_PW = 2'h1;
  localparam ST_UNLOCKED = 2'h2;
  reg [1:0] state, next_state;
  reg [1:0] op_adjust_lock_level, init_comm_lock_level;
  reg change_lock, fkey_lock, pw_written;
  reg [15:0] protect_entry_password_store, protect_entry_password_input, hold_ms;
  reg [31:0] workbit_cfg;
  reg [9:0] route;
  reg [NCOND-1:0] cond_enable;
  wire hold_reached, work_bit, wr_fire, rd_fire, lock_writable;
  wire [31:0] wmask;

  fppg_hold_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_hold (
    .clk(CLOCK),
    .rst(RST),
    .keys_held(KEY_LEVEL & KEY_MODE),
    .hold_ms(hold_ms),
    .reached(hold_reached)
  );

  fppg_work_bit u_work (
    .cfg(workbit_cfg),
    .alarm1(ALARM1),
    .run(RUN),
    .result(work_bit)
  );

  // Drives one output from its route code.
  function route_value;
    input [1:0] code;
    input a1;
    input wb;
    input ctl;
    begin
      case (code)
        `FPPG_ROUTE_ALARM1: route_value = a1;
        `FPPG_ROUTE_WORKBIT: route_value = wb;
        `FPPG_ROUTE_CONTROL: route_value = ctl;
        default: route_value = 1'b0;
      endcase
    end
  endfunction

  // Tells whether a route code counts as an alarm assignment.
  function is_alarm;
    input [1:0] code;
    begin
      is_alarm = (code == `FPPG_ROUTE_ALARM1) || (code == `FPPG_ROUTE_WORKBIT);
    end
  endfunction

  // Level sequencing between operation and protect levels.
  always @*
  begin
    next_state = state;
    case (state)
      ST_OPER:
        if (hold_reached)
          next_state = (protect_entry_password_store != 16'h0000) ? ST_PW : ST_UNLOCKED;
      ST_PW:
        if (hold_reached)
          next_state = ST_OPER;
        else if (pw_written && protect_entry_password_input == protect_entry_password_store)
          next_state = ST_UNLOCKED;
      ST_UNLOCKED:
        if (hold_reached)
          next_state = ST_OPER;
      default: next_state = ST_OPER;
    endcase
  end

  always @(posedge CLOCK)
  begin
    if (RST)
      state <= ST_OPER;
    else
      state <= next_state;
  end

  // AXI4-Lite handshakes: address and data are taken together, one at a time.
  assign wr_fire = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID && !S_AXI_AWREADY;
  assign rd_fire = S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY;
  assign wmask = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
                  {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
  // Lock settings change only from the unlocked protect level.
  assign lock_writable = (state == ST_UNLOCKED);

  always @(posedge CLOCK)
  begin
    if (RST)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `FPPG_RESP_OKAY;
      op_adjust_lock_level <= 2'h0;
      init_comm_lock_level <= 2'h0;
      change_lock <= 1'b0;
      fkey_lock <= 1'b0;
      protect_entry_password_store <= `FPPG_RST_PW;
      protect_entry_password_input <= `FPPG_RST_PW;
      pw_written <= 1'b0;
      hold_ms <= `FPPG_HOLD_MS;
      workbit_cfg <= `FPPG_RST_WORKBIT;
      route <= 10'h000;
      cond_enable <= {NCOND{1'b1}};
    end
    else
    begin
      S_AXI_AWREADY <= wr_fire;
      S_AXI_WREADY <= wr_fire;
      pw_written <= 1'b0;
      if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      if (state == ST_OPER)
        protect_entry_password_input <= `FPPG_RST_PW;
      if (wr_fire)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= `FPPG_RESP_OKAY;
        case (S_AXI_AWADDR)
          `FPPG_OFF_LOCK:
            if (lock_writable && S_AXI_WSTRB[0])
            begin
              op_adjust_lock_level <= S_AXI_WDATA[`FPPG_LOCK_OPADJ_LSB +: 2];
              init_comm_lock_level <= S_AXI_WDATA[`FPPG_LOCK_INIT_LSB +: 2];
              change_lock <= S_AXI_WDATA[`FPPG_LOCK_CHANGE_BIT];
              fkey_lock <= (HAS_FKEY != 0) && S_AXI_WDATA[`FPPG_LOCK_FKEY_BIT];
            end
          `FPPG_OFF_PW_STORE:
            if (lock_writable)
              protect_entry_password_store <= (protect_entry_password_store & ~wmask[15:0])
                                              | (S_AXI_WDATA[15:0] & wmask[15:0]);
          `FPPG_OFF_PW_INPUT:
            if (state == ST_PW)
            begin
              protect_entry_password_input <= S_AXI_WDATA[15:0];
              pw_written <= 1'b1;
            end
          `FPPG_OFF_HOLD:
            hold_ms <= (hold_ms & ~wmask[15:0]) | (S_AXI_WDATA[15:0] & wmask[15:0]);
          `FPPG_OFF_WORKBIT:
            workbit_cfg <= (workbit_cfg & ~wmask) | (S_AXI_WDATA & wmask);
          `FPPG_OFF_ROUTE:
            route <= (route & ~wmask[9:0]) | (S_AXI_WDATA[9:0] & wmask[9:0]);
          `FPPG_OFF_COND:
            cond_enable <= S_AXI_WDATA[NCOND-1:0];
          `FPPG_OFF_STATUS:
            S_AXI_BRESP <= `FPPG_RESP_OKAY;
          default:
            S_AXI_BRESP <= `FPPG_RESP_SLVERR;
        endcase
      end
    end
  end

  // Read channel returns registers in the same cycle that the address is taken.
  always @(posedge CLOCK)
  begin
    if (RST)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `FPPG_RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= rd_fire;
      if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
      if (rd_fire)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `FPPG_RESP_OKAY;
        S_AXI_RDATA <= 32'h00000000;
        case (S_AXI_ARADDR)
          `FPPG_OFF_LOCK:
            if (state == ST_UNLOCKED)
              S_AXI_RDATA <= {26'h0, fkey_lock, change_lock,
                              init_comm_lock_level, op_adjust_lock_level};
          `FPPG_OFF_PW_STORE:
            if (state == ST_UNLOCKED)
              S_AXI_RDATA <= {{16{protect_entry_password_store[15]}},
                              protect_entry_password_store};
          `FPPG_OFF_PW_INPUT:
            S_AXI_RDATA <= 32'h00000000;
          `FPPG_OFF_HOLD:
            S_AXI_RDATA <= {16'h0000, hold_ms};
          `FPPG_OFF_WORKBIT:
            S_AXI_RDATA <= workbit_cfg;
          `FPPG_OFF_ROUTE:
            S_AXI_RDATA <= {22'h000000, route};
          `FPPG_OFF_STATUS:
            S_AXI_RDATA <= {23'h000000, work_bit, ALARM_PARAMS_ON,
                            SHOW_LOCK_SETTINGS, SHOW_PW_PROMPT, IN_PROTECT,
                            ADJ_ALLOWED, SP_EDITABLE, state};
          `FPPG_OFF_COND:
            S_AXI_RDATA <= {{(32-NCOND){1'b0}}, cond_enable};
          default:
            S_AXI_RRESP <= `FPPG_RESP_SLVERR;
        endcase
      end
    end
  end

  // Display gating and level moves; protection never alters stored values.
  always @(posedge CLOCK)
  begin
    if (RST)
    begin
      IN_PROTECT <= 1'b0;
      SHOW_PW_PROMPT <= 1'b0;
      SHOW_LOCK_SETTINGS <= 1'b0;
      SHOW_PV <= 1'b1;
      SHOW_SP <= 1'b1;
      SP_EDITABLE <= 1'b1;
      SHOW_OTHER <= {NCOND{1'b0}};
      ADJ_ALLOWED <= 1'b1;
      INIT_ALLOWED <= 1'b1;
      COMM_ALLOWED <= 1'b1;
      ADV_ALLOWED <= 1'b1;
      KEY_CHANGE_ALLOWED <= 1'b1;
      FKEY_ALLOWED <= (HAS_FKEY != 0);
      ALARM_PARAMS_ON <= 1'b0;
    end
    else
    begin
      IN_PROTECT <= (state != ST_OPER);
      SHOW_PW_PROMPT <= (state == ST_PW);
      SHOW_LOCK_SETTINGS <= (state == ST_UNLOCKED);
      SP_EDITABLE <= (op_adjust_lock_level != 2'h3) && !change_lock;
      SHOW_OTHER <= (op_adjust_lock_level >= 2'h2) ? {NCOND{1'b0}}
                    : (COND_MET & cond_enable);
      ADJ_ALLOWED <= (op_adjust_lock_level == 2'h0);
      INIT_ALLOWED <= (init_comm_lock_level < 2'h2);
      COMM_ALLOWED <= (init_comm_lock_level < 2'h2);
      ADV_ALLOWED <= (init_comm_lock_level == 2'h0);
      KEY_CHANGE_ALLOWED <= !change_lock;
      FKEY_ALLOWED <= (HAS_FKEY != 0) && !fkey_lock;
      ALARM_PARAMS_ON <= is_alarm(route[1:0]) || is_alarm(route[3:2]) ||
                         is_alarm(route[5:4]) || is_alarm(route[7:6]) ||
                         is_alarm(route[9:8]);
    end
  end

  // Output pins follow their routed sources.
  always @(posedge CLOCK)
  begin
    if (RST)
    begin
      OUT_CTRL1 <= 1'b0;
      OUT_CTRL2 <= 1'b0;
      OUT_AUX1 <= 1'b0;
      OUT_AUX2 <= 1'b0;
      OUT_AUX3 <= 1'b0;
    end
    else
    begin
      OUT_CTRL1 <= route_value(route[1:0], ALARM1, work_bit, CONTROL_OUT);
      OUT_CTRL2 <= route_value(route[3:2], ALARM1, work_bit, CONTROL_OUT);
      OUT_AUX1 <= route_value(route[5:4], ALARM1, work_bit, CONTROL_OUT);
      OUT_AUX2 <= route_value(route[7:6], ALARM1, work_bit, CONTROL_OUT);
      OUT_AUX3 <= route_value(route[9:8], ALARM1, work_bit, CONTROL_OUT);
    end
  end
endmodule

// ---- rtl/fppg_work_bit.v ----
`timescale 1ns/1ps
`include "fppg_defs.vh"

// Combines four selected inputs into one work bit: (A and B) or (C and D).
module fppg_work_bit (
  input wire [31:0] cfg,
  input wire alarm1,
  input wire run,
  output wire result
);
  // Maps a selection code to its source; unknown codes read as false.
  function pick;
    input [4:0] code;
    input a1;
    input r;
    begin
      case (code)
        `FPPG_SEL_OFF: pick = 1'b0;
        `FPPG_SEL_ALARM1: pick = a1;
        // The run/stop status is high in STOP, so its inverse is the RUN level.
        `FPPG_SEL_RUN_INV: pick = r;
        default: pick = 1'b0;
      endcase
    end
  endfunction

  wire in_a = pick(cfg[4:0], alarm1, run);
  wire in_b = pick(cfg[12:8], alarm1, run);
  wire in_c = pick(cfg[20:16], alarm1, run);
  wire in_d = pick(cfg[28:24], alarm1, run);

  // Alarm 1 with inverted run/stop passes alarm 1 only during RUN.
  assign result = (in_a & in_b) | (in_c & in_d);
endmodule

// ---- test/fppg_key_panel.sv ----
`timescale 1ns/1ps
// Operator model: one press closes both entry keys together.
module fppg_key_panel (
  input wire clk,
  input wire press,
  output reg key_level = 1'h0,
  output reg key_mode = 1'h0
);
  // Both keys follow the press on the clock edge.
  always @(posedge clk)
  begin
    key_level <= press;
    key_mode <= press;
  end
endmodule

// ---- test/fppg_top_properties.sv ----
`timescale 1ns/1ps
module fppg_props #(
  parameter HAS_FKEY = 1,
  parameter NCOND = 8
) (
  input wire CLOCK,
  input wire RST,
  input wire KEY_LEVEL,
  input wire KEY_MODE,
  input wire [NCOND-1:0] COND_MET,
  input wire IN_PROTECT,
  input wire SHOW_PV,
  input wire SHOW_SP,
  input wire [NCOND-1:0] SHOW_OTHER,
  input wire INIT_ALLOWED,
  input wire COMM_ALLOWED,
  input wire ADV_ALLOWED,
  input wire FKEY_ALLOWED,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // A write request and its one-cycle answer.
  sequence s_wr_req;
    S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID && !S_AXI_AWREADY;
  endsequence
  sequence s_wr_ans;
    S_AXI_AWREADY && S_AXI_WREADY && S_AXI_BVALID;
  endsequence
  sequence s_keys_held;
    $past(KEY_LEVEL, 3) && $past(KEY_MODE, 3);
  endsequence
  property p_wr_ans; s_wr_req |=> s_wr_ans; endproperty
  property p_aw_pulse; S_AXI_AWREADY |=> !S_AXI_AWREADY; endproperty
  property p_rd_ans;
    S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY |=> S_AXI_ARREADY && S_AXI_RVALID;
  endproperty
  property p_pv_sp; SHOW_PV && SHOW_SP; endproperty
  property p_cond; !(SHOW_OTHER & ~$past(COND_MET)); endproperty
  property p_enter; $rose(IN_PROTECT) |-> s_keys_held; endproperty
  property p_leave; $fell(IN_PROTECT) |-> s_keys_held; endproperty
  property p_init_comm; INIT_ALLOWED == COMM_ALLOWED; endproperty
  property p_adv; ADV_ALLOWED |-> INIT_ALLOWED; endproperty
  property p_fkey; FKEY_ALLOWED |-> HAS_FKEY != 0; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered in one cycle");
  a_aw_pulse: assert property (p_aw_pulse) else $error("write ready held too long");
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered in one cycle");
  a_pv_sp: assert property (p_pv_sp) else $error("process value or set point hidden");
  a_cond: assert property (p_cond) else $error("item shown without its condition");
  a_enter: assert property (p_enter) else $error("protect entered without keys");
  a_leave: assert property (p_leave) else $error("protect left without keys");
  a_init_comm: assert property (p_init_comm) else $error("initial and comm gates differ");
  a_adv: assert property (p_adv) else $error("advanced open while initial closed");
  a_fkey: assert property (p_fkey) else $error("function key allowed without key");
endmodule
bind fppg_top fppg_props #(.HAS_FKEY(HAS_FKEY), .NCOND(NCOND)) u_props (.CLOCK, .RST,
  .KEY_LEVEL, .KEY_MODE, .COND_MET, .IN_PROTECT, .SHOW_PV, .SHOW_SP, .SHOW_OTHER,
  .INIT_ALLOWED, .COMM_ALLOWED, .ADV_ALLOWED, .FKEY_ALLOWED, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID);

// ---- test/test_front_panel_protect_gate.sv ----
`timescale 1ns/1ps
`include "fppg_defs.vh"
module test_front_panel_protect_gate;
  reg CLOCK = 1'h0;
  reg RST = 1'h1;
  reg press = 1'h0;
  reg ALARM1 = 1'h0, RUN = 1'h0, CONTROL_OUT = 1'h0;
  reg [7:0] COND_MET = 8'hFF, S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  reg [31:0] S_AXI_WDATA = 32'h0;
  reg [3:0] S_AXI_WSTRB = 4'hF;
  reg S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  reg S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
  wire KEY_LEVEL, KEY_MODE, IN_PROTECT, SHOW_PW_PROMPT, SHOW_LOCK_SETTINGS, SHOW_PV, SHOW_SP;
  wire SP_EDITABLE, ADJ_ALLOWED, INIT_ALLOWED, COMM_ALLOWED, ADV_ALLOWED, KEY_CHANGE_ALLOWED;
  wire FKEY_ALLOWED, ALARM_PARAMS_ON, OUT_CTRL1, OUT_CTRL2, OUT_AUX1, OUT_AUX2, OUT_AUX3;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  wire [7:0] SHOW_OTHER;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  integer num_errors = 0, num_checks = 0, i, n;
  reg [31:0] rd;
  reg [1:0] rsp;
  // The clock toggles every half period of 50 ns, a period of 100 ns.
  always #50 CLOCK = ~CLOCK;
  fppg_key_panel u_keys (.clk(CLOCK), .press(press), .key_level(KEY_LEVEL), .key_mode(KEY_MODE));
  fppg_top #(.TICK_CYCLES(4)) u_dut (.CLOCK, .RST, .KEY_LEVEL, .KEY_MODE, .ALARM1, .RUN,
    .CONTROL_OUT, .COND_MET, .IN_PROTECT, .SHOW_PW_PROMPT, .SHOW_LOCK_SETTINGS, .SHOW_PV,
    .SHOW_SP, .SP_EDITABLE, .SHOW_OTHER, .ADJ_ALLOWED, .INIT_ALLOWED, .COMM_ALLOWED,
    .ADV_ALLOWED, .KEY_CHANGE_ALLOWED, .FKEY_ALLOWED, .ALARM_PARAMS_ON, .OUT_CTRL1, .OUT_CTRL2,
    .OUT_AUX1, .OUT_AUX2, .OUT_AUX3, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY);
  // Counts a comparison and reports a mismatch.
  task check(input [31:0] seen, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  // One write; each channel is released when taken, outputs settle after.
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    n = 0;
    do
    begin
      @(posedge CLOCK);
      n = n + 1;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
    end while (S_AXI_BVALID !== 1'h1 && n < 50);
    if (S_AXI_BVALID !== 1'h1) num_errors = num_errors + 1;
    rsp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'h0;
    repeat (3) @(posedge CLOCK);
  end
  endtask
  // One read; data and response are taken at the edge with valid.
  task rdr(input [7:0] a);
  begin
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    n = 0;
    do
    begin
      @(posedge CLOCK);
      n = n + 1;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
    end while (S_AXI_RVALID !== 1'h1 && n < 50);
    if (S_AXI_RVALID !== 1'h1) num_errors = num_errors + 1;
    rd = S_AXI_RDATA;
    rsp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'h0;
  end
  endtask
  // Holds both keys until the protect flag reaches the wanted level.
  task keys(input want);
  begin
    @(posedge CLOCK);
    press <= 1'h1;
    n = 0;
    while (IN_PROTECT !== want && n < 200)
    begin
      @(posedge CLOCK);
      n = n + 1;
    end
    if (IN_PROTECT !== want) num_errors = num_errors + 1;
    press <= 1'h0;
    repeat (3) @(posedge CLOCK);
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  // The watchdog ends a hung run as a failure.
  initial
  begin
    #3000000;
    num_errors = num_errors + 1;
    wrap_up;
  end
  // Main sequence of register and key operations.
  initial
  begin
    repeat (2) @(posedge CLOCK);
    RST <= 1'h0;
    rdr(`FPPG_OFF_HOLD);
    check(rd, 32'h00000BB8);
    rdr(`FPPG_OFF_WORKBIT);
    check(rd, `FPPG_RST_WORKBIT);
    check(ADJ_ALLOWED, 1'h1);
    wr(`FPPG_OFF_HOLD, 32'h3);
    check(rsp, `FPPG_RESP_OKAY);
    press <= 1'h1;
    repeat (6) @(posedge CLOCK);
    press <= 1'h0;
    repeat (20) @(posedge CLOCK);
    check(IN_PROTECT, 1'h0);
    keys(1'h1);
    check(n >= 9 && n <= 24, 1'h1);
    check(SHOW_PW_PROMPT, 1'h0);
    check(SHOW_LOCK_SETTINGS, 1'h1);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`FPPG_OFF_LOCK, ((i % 3) << 2) | i);
      check(ADJ_ALLOWED, i == 0);
      check(SP_EDITABLE, i != 3);
      check(SHOW_OTHER, i < 2 ? 8'hFF : 8'h00);
      check(INIT_ALLOWED, i % 3 < 2);
      check(ADV_ALLOWED, i % 3 == 0);
    end
    wr(`FPPG_OFF_LOCK, 32'h30);
    check({KEY_CHANGE_ALLOWED, SP_EDITABLE, FKEY_ALLOWED}, 3'h0);
    wr(`FPPG_OFF_LOCK, 32'h1);
    wr(`FPPG_OFF_PW_STORE, 32'hFFFFFFFB);
    rdr(`FPPG_OFF_PW_STORE);
    check(rd, 32'hFFFFFFFB);
    keys(1'h0);
    wr(`FPPG_OFF_LOCK, 32'h0);
    check(ADJ_ALLOWED, 1'h0);
    rdr(`FPPG_OFF_LOCK);
    check(rd, 32'h0);
    keys(1'h1);
    check(SHOW_PW_PROMPT, 1'h1);
    wr(`FPPG_OFF_PW_INPUT, 32'hFFFFFFFA);
    check(SHOW_LOCK_SETTINGS, 1'h0);
    wr(`FPPG_OFF_PW_INPUT, 32'hFFFFFFFB);
    check(SHOW_LOCK_SETTINGS, 1'h1);
    wr(`FPPG_OFF_LOCK, 32'h0);
    check(ADJ_ALLOWED, 1'h1);
    wr(`FPPG_OFF_COND, 32'h0F);
    check(SHOW_OTHER, 8'h0F);
    COND_MET <= 8'h3C;
    repeat (3) @(posedge CLOCK);
    check(SHOW_OTHER, 8'h0C);
    for (i = 0; i < 5; i = i + 1)
    begin
      wr(`FPPG_OFF_ROUTE, 32'h2 << (2 * i));
      check(ALARM_PARAMS_ON, 1'h1);
    end
    wr(`FPPG_OFF_ROUTE, 32'h3);
    check(ALARM_PARAMS_ON, 1'h0);
    wr(`FPPG_OFF_ROUTE, 32'h16B);
    for (i = 0; i < 8; i = i + 1)
    begin
      {CONTROL_OUT, ALARM1, RUN} <= i[2:0];
      repeat (3) @(posedge CLOCK);
      check({OUT_AUX1, OUT_CTRL2, OUT_AUX2, OUT_AUX3, OUT_CTRL1},
            {i[1] & i[0], i[1] & i[0], i[1], i[1], i[2]});
    end
    wr(`FPPG_OFF_WORKBIT, 32'h7);
    RUN <= 1'h1;
    repeat (3) @(posedge CLOCK);
    check(OUT_AUX1, 1'h0);
    rdr(8'h20);
    check(rsp, `FPPG_RESP_SLVERR);
    check(rd, 32'h0);
    wr(8'h20, 32'h1);
    check(rsp, `FPPG_RESP_SLVERR);
    wrap_up;
  end
endmodule
